// [ssw_defines.svh]
// Timing and index constants for the supply supervisor watchdog
`ifndef SSW_DEFINES_SVH
`define SSW_DEFINES_SVH
// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define SSW_CLK_KHZ 200000
`define SSW_CLK_PERIOD_NS 5
`define SSW_TIMEOUT_MS 100
`define SSW_TIMEOUT_CYC (`SSW_TIMEOUT_MS * `SSW_CLK_KHZ)
`define SSW_DEBOUNCE_DIV 64
`define SSW_DIP_MIN_NS 10000
`define SSW_DIP_MIN_CYC ((`SSW_DIP_MIN_NS + `SSW_CLK_PERIOD_NS - 1) / `SSW_CLK_PERIOD_NS)
// ----------------------------------------------------------------
// Synchroniser bit positions
// ----------------------------------------------------------------
`define SSW_IN_SUPPLY 0
`define SSW_IN_HIGH 1
`define SSW_IN_WARN 2
`define SSW_IN_FAIL 3
`define SSW_IN_KICK 4
`define SSW_IN_WIDTH 5
// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define SSW_HOLD_RESET 1'b1
`define SSW_SAVE_N_RESET 1'b0
`endif

// [ssw_host_model.sv]
// Host processor model that kicks the watchdog clear input
`timescale 1ns/100ps
module ssw_host_model #(
  parameter int unsigned KICK_GAP = 100
) (
  input wire logic clk,
  input wire logic kick_en,
  output logic kick_n
);
  int unsigned cnt = 0;
  logic kick_q = 1'b1;
  assign kick_n = kick_q;
  // Four cycle low pulse, repeated well inside one timeout
  always @(posedge clk) begin
    cnt <= (kick_en && cnt < KICK_GAP) ? cnt + 1 : 0;
    kick_q <= !(kick_en && cnt < 4);
  end
endmodule // ssw_host_model

// [ssw_pkg.sv]
// Types for the supply supervisor watchdog
package ssw_pkg;
  typedef enum logic [3:0] {
    SSW_OFF      = 4'h1,
    SSW_DEBOUNCE = 4'h2,
    SSW_POR      = 4'h4,
    SSW_RUN      = 4'h8
  } ssw_state_type;
endpackage

// [ssw_supervisor.sv]
// Supply supervisor with self recovering watchdog timer
`timescale 1ns/100ps
// Contract
// - Rail below activation holds both resets and warning active, sense ignored.
// - Rail lost disables timer and sense monitoring, forces all outputs active.
// - Rail good and sense high: release warning, start timer, release resets after timeout.
// - Sense below warn asserts warning until sense rises above high level.
// - Sense below fail asserts both resets and halts the timer.
// - After fail drop, new power-up starts when sense rises above high level.
// - Timer expiry drives resets even while supply levels are good.
// - Sense good before rail defers power-on until the rail is good.
// - Timeout period defaults to 100 ms, carried as a parameter.
// - Power-on condition debounced for one sixty-fourth of the timeout.
// - Debounce restarts on any sense dip sampled at a clock edge, including dips shorter than 10 us.
// - Two reset outputs, same condition, opposite polarity.
// - Host kicks before timeout; falling edge zeroes timer and releases resets.
// - Unkicked resets toggle each timeout, square wave starting inactive.
// - Kicks ignored until the power-on delay has finished.
// - Fail drop overrides timer at once; kicks ignored until power-up completes.
`include "ssw_defines.svh"
module ssw_supervisor #(
  parameter int unsigned TIMEOUT_CYCLES = `SSW_TIMEOUT_CYC,
  parameter int unsigned DEBOUNCE_CYCLES = TIMEOUT_CYCLES / `SSW_DEBOUNCE_DIV
) (
  input wire logic CLK,
  input wire logic RST_N,
  input wire logic SUPPLY_GOOD_LEVEL,
  input wire logic SENSE_HIGH_LEVEL,
  input wire logic SENSE_WARN_LEVEL,
  input wire logic SENSE_FAIL_LEVEL,
  input wire logic KICK_CLEAR_N,
  output logic SYS_HOLD_OUT,
  output logic SYS_HOLD_OUT_N,
  output logic SAVE_N
);
  // ----------------------------------------------------------------
  // Input synchronisers
  // ----------------------------------------------------------------
  logic [`SSW_IN_WIDTH-1:0] meta_q;
  logic [`SSW_IN_WIDTH-1:0] sync_q;
  logic [`SSW_IN_WIDTH-1:0] sync_d;
  logic kick_prev_q;
  logic kick_prev_d;

  always_comb begin
    sync_d = {KICK_CLEAR_N, SENSE_FAIL_LEVEL, SENSE_WARN_LEVEL, SENSE_HIGH_LEVEL, SUPPLY_GOOD_LEVEL};
    kick_prev_d = sync_q[`SSW_IN_KICK];
  end

  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      meta_q <= 5'h00;
      sync_q <= 5'h00;
      kick_prev_q <= 1'b0;
    end else begin
      meta_q <= sync_d;
      sync_q <= meta_q;
      kick_prev_q <= kick_prev_d;
    end
  end

  logic supply_ok;
  logic high_ok;
  logic warn_ok;
  logic fail_ok;
  logic kick_fall;
  logic live_ok;

  assign supply_ok = sync_q[`SSW_IN_SUPPLY];
  assign high_ok = sync_q[`SSW_IN_HIGH];
  assign warn_ok = sync_q[`SSW_IN_WARN];
  assign fail_ok = sync_q[`SSW_IN_FAIL];
  assign kick_fall = kick_prev_q & ~sync_q[`SSW_IN_KICK];
  assign live_ok = supply_ok & fail_ok;

  // ----------------------------------------------------------------
  // Sequencer and timeout timer
  // ----------------------------------------------------------------
  ssw_pkg::ssw_state_type state_q;
  ssw_pkg::ssw_state_type state_d;
  logic [31:0] cnt_q;
  logic [31:0] cnt_d;
  logic hold_q;
  logic hold_d;
  logic hold_n_q;
  logic hold_n_d;
  logic save_n_q;
  logic save_n_d;
  logic [31:0] to_last;
  logic [31:0] db_last;

  assign to_last = 32'(TIMEOUT_CYCLES - 1);
  assign db_last = 32'(DEBOUNCE_CYCLES - 1);

  always_comb begin
    state_d = state_q;
    cnt_d = cnt_q;
    hold_d = hold_q;
    save_n_d = save_n_q;
    unique case (state_q)
      ssw_pkg::SSW_OFF: begin
        hold_d = 1'b1;
        save_n_d = 1'b0;
        cnt_d = 32'h0000_0000;
        if (supply_ok && high_ok) begin
          state_d = ssw_pkg::SSW_DEBOUNCE;
        end
      end
      ssw_pkg::SSW_DEBOUNCE: begin
        if (!(supply_ok && high_ok)) begin
          state_d = ssw_pkg::SSW_OFF;
          cnt_d = 32'h0000_0000;
        end else if (cnt_q >= db_last) begin
          state_d = ssw_pkg::SSW_POR;
          save_n_d = 1'b1;
          cnt_d = 32'h0000_0000;
        end else begin
          cnt_d = cnt_q + 32'h0000_0001;
        end
      end
      ssw_pkg::SSW_POR: begin
        // Kicks have no effect here
        if (cnt_q >= to_last) begin
          state_d = ssw_pkg::SSW_RUN;
          hold_d = 1'b0;
          cnt_d = 32'h0000_0000;
        end else begin
          cnt_d = cnt_q + 32'h0000_0001;
        end
      end
      ssw_pkg::SSW_RUN: begin
        if (kick_fall) begin
          hold_d = 1'b0;
          cnt_d = 32'h0000_0000;
        end else if (cnt_q >= to_last) begin
          hold_d = ~hold_q;
          cnt_d = 32'h0000_0000;
        end else begin
          cnt_d = cnt_q + 32'h0000_0001;
        end
      end
    endcase
    if (state_q != ssw_pkg::SSW_OFF) begin
      if (!warn_ok) begin
        save_n_d = 1'b0;
      end else if (high_ok && state_q != ssw_pkg::SSW_DEBOUNCE) begin
        save_n_d = 1'b1;
      end
      if (!live_ok) begin
        state_d = ssw_pkg::SSW_OFF;
        hold_d = 1'b1;
        save_n_d = 1'b0;
        cnt_d = 32'h0000_0000;
      end
    end
    hold_n_d = ~hold_d;
  end

  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      state_q <= ssw_pkg::SSW_OFF;
      cnt_q <= 32'h0000_0000;
      hold_q <= `SSW_HOLD_RESET;
      hold_n_q <= ~`SSW_HOLD_RESET;
      save_n_q <= `SSW_SAVE_N_RESET;
    end else begin
      state_q <= state_d;
      cnt_q <= cnt_d;
      hold_q <= hold_d;
      hold_n_q <= hold_n_d;
      save_n_q <= save_n_d;
    end
  end

  assign SYS_HOLD_OUT = hold_q;
  assign SYS_HOLD_OUT_N = hold_n_q;
  assign SAVE_N = save_n_q;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RST_N);

  a_off_outputs: assert property (state_q == ssw_pkg::SSW_OFF |-> hold_q && !hold_n_q && !save_n_q)
    else $error("outputs not active while off");
  a_rail_lost: assert property (!supply_ok |=> state_q == ssw_pkg::SSW_OFF && hold_q)
    else $error("rail loss did not force off");
  a_fail_override: assert property (state_q != ssw_pkg::SSW_OFF && !fail_ok |=> hold_q && !save_n_q && cnt_q == 0)
    else $error("fail drop did not override timer");
  a_warn_set: assert property (state_q != ssw_pkg::SSW_OFF && live_ok && !warn_ok |=> !save_n_q)
    else $error("warning not asserted");
  a_debounce_end: assert property (state_q == ssw_pkg::SSW_DEBOUNCE && supply_ok && high_ok && fail_ok
    && cnt_q == db_last |=> state_q == ssw_pkg::SSW_POR && save_n_q && hold_q)
    else $error("debounce end wrong");
  a_por_release: assert property (state_q == ssw_pkg::SSW_POR && live_ok && cnt_q == to_last
    |=> state_q == ssw_pkg::SSW_RUN && !hold_q)
    else $error("power-on delay release wrong");
  a_kick_ignored: assert property (state_q == ssw_pkg::SSW_POR && live_ok && cnt_q != to_last
    |=> hold_q && cnt_q == $past(cnt_q) + 1)
    else $error("kick acted during power-on delay");
  a_kick_clear: assert property (state_q == ssw_pkg::SSW_RUN && live_ok && kick_fall |=> !hold_q && cnt_q == 0)
    else $error("kick did not clear timer");
  a_toggle: assert property (state_q == ssw_pkg::SSW_RUN && live_ok && !kick_fall && cnt_q == to_last
    |=> hold_q != $past(hold_q))
    else $error("timeout did not toggle resets");
  a_polarity: assert property (hold_q != hold_n_q)
    else $error("reset outputs not complementary");
  a_warn_hold: assert property (state_q != ssw_pkg::SSW_OFF && live_ok && !high_ok && !save_n_q
    |=> !save_n_q)
    else $error("warning released before sense recovered");
  a_warn_release: assert property (state_q == ssw_pkg::SSW_RUN && live_ok && warn_ok && high_ok |=> save_n_q)
    else $error("warning not released");
  a_defer: assert property (state_q == ssw_pkg::SSW_OFF && !supply_ok |=> state_q == ssw_pkg::SSW_OFF)
    else $error("power-on started without good rail");
  a_timer_halt: assert property (state_q == ssw_pkg::SSW_OFF |-> cnt_q == 0)
    else $error("timer running while off");

  c_power_up: cover property (state_q == ssw_pkg::SSW_POR ##1 state_q == ssw_pkg::SSW_RUN);
  c_kick: cover property (state_q == ssw_pkg::SSW_RUN && kick_fall);
  c_toggle: cover property (state_q == ssw_pkg::SSW_RUN && !hold_q ##1 hold_q);
  c_fail: cover property (state_q == ssw_pkg::SSW_RUN ##1 state_q == ssw_pkg::SSW_OFF);
endmodule // ssw_supervisor

// [tb_supply_supervisor_watchdog.sv]
// Self checking bench for the supply supervisor watchdog
`timescale 1ns/100ps
`include "ssw_defines.svh"
module tb_supply_supervisor_watchdog;
  localparam int unsigned TO = 640;
  localparam int unsigned DB = 10;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic supply = 1'b0;
  logic high = 1'b0;
  logic warn = 1'b0;
  logic fail = 1'b0;
  logic kick_en = 1'b0;
  logic kick_n;
  logic hold;
  logic hold_n;
  logic save_n;
  int errors = 0;
  int checks_done = 0;
  int m_state = 0;
  int m_cnt = 0;
  logic m_hold = 1'b1;
  logic m_save_n = 1'b0;
  logic [4:0] pin_hist[$];
  always #2.5 clk = ~clk;
  ssw_supervisor #(.TIMEOUT_CYCLES(TO), .DEBOUNCE_CYCLES(DB)) dut (.CLK(clk), .RST_N(rst_n),
    .SUPPLY_GOOD_LEVEL(supply), .SENSE_HIGH_LEVEL(high), .SENSE_WARN_LEVEL(warn),
    .SENSE_FAIL_LEVEL(fail), .KICK_CLEAR_N(kick_n), .SYS_HOLD_OUT(hold),
    .SYS_HOLD_OUT_N(hold_n), .SAVE_N(save_n));
  ssw_host_model #(.KICK_GAP(100)) host (.clk(clk), .kick_en(kick_en), .kick_n(kick_n));
  task automatic step(input int unsigned n);
    repeat (n) @(posedge clk);
  endtask
  // Unkicked hold level a given number of cycles into the run phase
  function automatic logic run_hold(input int unsigned cyc);
    return ((cyc / TO) % 2) == 1;
  endfunction
  // Checks settled outputs, then returns on a rising edge for the next drive
  task automatic cmp(input logic eh, input logic es);
    @(negedge clk);
    checks_done += 2;
    if ({hold, hold_n, save_n} !== {eh, ~eh, es}) begin
      errors++;
      $display("ERROR at %0t: outputs %h expected %h", $time, {hold, hold_n, save_n}, {eh, ~eh, es});
    end
    if ({hold, hold_n, save_n} !== {m_hold, ~m_hold, m_save_n}) begin
      errors++;
      $display("ERROR at %0t: outputs %h model %h", $time, {hold, hold_n, save_n}, {m_hold, ~m_hold, m_save_n});
    end
    @(posedge clk);
  endtask
  task automatic done(input string name);
    $display("Test %s finished", name);
  endtask
  task automatic print_verdict();
    $display("Checks %0d, mismatches %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  // ------------------------------------------------------------
  // Reference model
  // ------------------------------------------------------------
  // Pin history stands in for the two synchroniser stages
  always @(posedge clk) begin
    int old_state;
    logic [4:0] lv;
    logic kf;
    pin_hist.push_front(rst_n ? {kick_n, fail, warn, high, supply} : 5'h00);
    if (pin_hist.size() > 4) begin
      void'(pin_hist.pop_back());
    end
    if (!rst_n) begin
      m_state = 0;
      m_cnt = 0;
      m_hold = 1'b1;
      m_save_n = 1'b0;
    end else begin
      lv = pin_hist[2];
      kf = pin_hist[3][`SSW_IN_KICK] && !lv[`SSW_IN_KICK];
      old_state = m_state;
      case (m_state)
        0: begin
          m_hold = 1'b1;
          m_save_n = 1'b0;
          m_cnt = 0;
          if (lv[`SSW_IN_SUPPLY] && lv[`SSW_IN_HIGH]) begin
            m_state = 1;
          end
        end
        1: begin
          if (!(lv[`SSW_IN_SUPPLY] && lv[`SSW_IN_HIGH])) begin
            m_state = 0;
            m_cnt = 0;
          end else if (m_cnt == DB - 1) begin
            m_state = 2;
            m_save_n = 1'b1;
            m_cnt = 0;
          end else begin
            m_cnt++;
          end
        end
        2: begin
          if (m_cnt == TO - 1) begin
            m_state = 3;
            m_hold = 1'b0;
            m_cnt = 0;
          end else begin
            m_cnt++;
          end
        end
        default: begin
          if (kf) begin
            m_hold = 1'b0;
            m_cnt = 0;
          end else if (m_cnt == TO - 1) begin
            m_hold = !m_hold;
            m_cnt = 0;
          end else begin
            m_cnt++;
          end
        end
      endcase
      if (old_state != 0 && !lv[`SSW_IN_WARN]) begin
        m_save_n = 1'b0;
      end else if (old_state >= 2 && lv[`SSW_IN_HIGH]) begin
        m_save_n = 1'b1;
      end
      if (old_state != 0 && !(lv[`SSW_IN_SUPPLY] && lv[`SSW_IN_FAIL])) begin
        m_state = 0;
        m_hold = 1'b1;
        m_save_n = 1'b0;
        m_cnt = 0;
      end
    end
  end
  // ------------------------------------------------------------
  // Watchdog
  // ------------------------------------------------------------
  initial begin
    // Roughly twice the length of all tests
    step(TO * 16);
    errors++;
    print_verdict();
  end
  // ------------------------------------------------------------
  // Stimulus
  // ------------------------------------------------------------
  initial begin
    void'($urandom(32'h3058));
    step(3);
    rst_n <= 1'b1;
    cmp(1'b1, 1'b0);
    high <= 1'b1;
    warn <= 1'b1;
    fail <= 1'b1;
    step(50 + $urandom % 16);
    cmp(1'b1, 1'b0);
    supply <= 1'b1;
    kick_en <= 1'b1;
    step(DB + 10);
    cmp(1'b1, 1'b1);
    step(TO - 100);
    cmp(1'b1, 1'b1);
    kick_en <= 1'b0;
    step(TO / 4);
    cmp(run_hold(TO / 8), 1'b1);
    step(TO);
    cmp(run_hold(TO + TO / 8), 1'b1);
    done("power up and free run");
    kick_en <= 1'b1;
    step(120);
    cmp(1'b0, 1'b1);
    step(TO * 2 + $urandom % 16);
    cmp(1'b0, 1'b1);
    warn <= 1'b0;
    high <= 1'b0;
    step(10);
    cmp(1'b0, 1'b0);
    warn <= 1'b1;
    step(10);
    cmp(1'b0, 1'b0);
    high <= 1'b1;
    step(10);
    cmp(1'b0, 1'b1);
    done("kick and warning");
    fail <= 1'b0;
    warn <= 1'b0;
    high <= 1'b0;
    step(6);
    cmp(1'b1, 1'b0);
    step(TO * 2 + $urandom % 16);
    cmp(1'b1, 1'b0);
    fail <= 1'b1;
    warn <= 1'b1;
    high <= 1'b1;
    step(5);
    // Short dip in mid debounce restarts it
    high <= 1'b0;
    step(2 + $urandom % 3);
    high <= 1'b1;
    step(8);
    cmp(1'b1, 1'b0);
    step(DB + 2);
    cmp(1'b1, 1'b1);
    step(TO - 100);
    cmp(1'b1, 1'b1);
    step(150);
    cmp(1'b0, 1'b1);
    supply <= 1'b0;
    step(6);
    cmp(1'b1, 1'b0);
    done("fail drop and rail loss");
    print_verdict();
  end
endmodule // tb_supply_supervisor_watchdog
